// >>> aluj_pkg.sv
// Shared operation codes, flag positions, register offsets and cycle counts
package aluj_pkg;

  // Operations issued by the instruction decoder
  typedef enum logic [5:0] {
    OP_NOP,
    OP_ADD,
    OP_ADC,
    OP_SUB,
    OP_SUB_REGS_CARRY,
    OP_SUB_IMM,
    OP_SUB_IMM_CARRY,
    OP_ADD_IMM_WORD,
    OP_SUB_IMM_WORD,
    OP_AND,
    OP_AND_IMM,
    OP_OR,
    OP_OR_IMM,
    OP_XOR_REGS,
    OP_ONES_COMPLEMENT,
    OP_TWOS_COMPLEMENT,
    OP_SET_BITS_MASK,
    OP_CLEAR_BITS_MASK,
    OP_INCREMENT_REG,
    OP_DECREMENT_REG,
    OP_TEST_REG,
    OP_ZERO_REG,
    OP_FILL_REG_ONES,
    OP_MULT_UNSIGNED,
    OP_MULT_SIGNED,
    OP_MULT_SIGNED_UNSIGNED,
    OP_FRAC_MULT_UNSIGNED,
    OP_FRAC_MULT_SIGNED,
    OP_FRAC_MULT_SIGNED_UNSIGNED,
    OP_RELATIVE_JUMP,
    OP_POINTER_JUMP,
    OP_EXTENDED_POINTER_JUMP,
    OP_ABSOLUTE_JUMP,
    OP_RELATIVE_CALL,
    OP_POINTER_CALL,
    OP_EXTENDED_POINTER_CALL
  } aluj_op_e;

  // Bit positions inside the status flag byte
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // Register port offsets
  localparam logic [1:0] REG_FLAGS  = 2'h0;
  localparam logic [1:0] REG_EXTIND = 2'h1;
  localparam logic [1:0] REG_STATE  = 2'h2;

  // Reset values
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] EXTIND_RST = 8'h00;

  // Constants used by the arithmetic
  localparam logic [7:0] ALL_ONES  = 8'hFF;
  localparam logic [7:0] ALL_ZERO  = 8'h00;
  localparam logic [7:0] MIN_NEG   = 8'h80;
  localparam logic [7:0] MAX_POS   = 8'h7F;

  // Cycles per operation class
  localparam logic [2:0] CYC_ONE    = 3'h1;
  localparam logic [2:0] CYC_TWO    = 3'h2;
  localparam logic [2:0] CYC_DIRECT = 3'h3;
  localparam logic [2:0] CYC_CALL   = 3'h4;

endpackage : aluj_pkg

// >>> aluj_mult.sv
// Eight by eight multiplier with signed, mixed and fractional modes
`timescale 1ns/100ps
module aluj_mult #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  input  wire logic           a_signed,
  input  wire logic           b_signed,
  input  wire logic           frac,
  output logic      [2*W-1:0] prod,
  output logic                carry
);

  logic signed [W:0]     a_ext;
  logic signed [W:0]     b_ext;
  logic signed [2*W+1:0] raw;

  // Extend each operand by its own sign rule, then multiply
  assign a_ext = $signed({a_signed & a[W-1], a});
  assign b_ext = $signed({b_signed & b[W-1], b});
  assign raw   = a_ext * b_ext;

  // Carry is the top product bit before any fractional shift
  assign carry = raw[2*W-1];
  assign prod  = frac ? {raw[2*W-2:0], 1'b0} : raw[2*W-1:0];

endmodule : aluj_mult

// >>> aluj_datapath.sv
// Arithmetic, logic, multiply and program flow datapath of the core
//
// Contract
// - Add registers, optional carry, flags, one cycle
// - Subtract registers, optional carry, flags, one cycle
// - Subtract immediate, optional carry, flags, one cycle
// - Add immediate to pair, two cycles
// - Subtract immediate from pair, two cycles
// - AND, OR, XOR set Z N V only
// - Set or clear bits by mask
// - Increment and decrement keep carry untouched
// - Test, clear set flags; fill ones none
// - Multiply variants into product pair, two cycles
// - Fractional multiply shifts product left once
// - Pointer jump loads PC from Z
// - Extended pointer jump uses extended register above Z
// - Pointer call loads PC from Z, four cycles
// - Extended pointer call, four cycles
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/100ps
module aluj_datapath #(
  parameter int PC_W  = 22,
  parameter int OFS_W = 12
) (
  input  wire logic                  CLK,
  input  wire logic                  RST_B,
  input  wire logic                  OP_START,
  input  wire aluj_pkg::aluj_op_e    OP_CODE,
  input  wire logic [7:0]            OP_D,
  input  wire logic [7:0]            OP_DH,
  input  wire logic [7:0]            OP_R,
  input  wire logic [7:0]            OP_K,
  input  wire logic [15:0]           OP_Z,
  input  wire logic [OFS_W-1:0]      OP_OFS,
  input  wire logic [PC_W-1:0]       OP_ADDR,
  input  wire logic [1:0]            REG_ADDR,
  input  wire logic [7:0]            REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic      [7:0]            REG_RDATA,
  output logic                       BUSY,
  output logic                       DONE,
  output logic      [7:0]            RES_LO,
  output logic      [7:0]            RES_HI,
  output logic                       WR_DEST,
  output logic                       WR_PAIR,
  output logic                       WR_PROD,
  output logic      [7:0]            FLAGS,
  output logic      [PC_W-1:0]       PC_OUT,
  output logic                       PC_LOAD,
  output logic                       CALL_PUSH,
  output logic      [PC_W-1:0]       RET_PC
);

  localparam int C = aluj_pkg::FLAG_C;
  localparam int Z = aluj_pkg::FLAG_Z;
  localparam int N = aluj_pkg::FLAG_N;
  localparam int V = aluj_pkg::FLAG_V;
  localparam int S = aluj_pkg::FLAG_S;
  localparam int H = aluj_pkg::FLAG_H;

  aluj_pkg::aluj_op_e op_r;
  logic [7:0]         d_r;
  logic [7:0]         dh_r;
  logic [7:0]         r_r;
  logic [7:0]         k_r;
  logic [15:0]        z_r;
  logic [OFS_W-1:0]   ofs_r;
  logic [PC_W-1:0]    addr_r;
  logic [2:0]         rem_r;
  logic [2:0]         rem_nxt;
  logic [7:0]         flags_r;
  logic [7:0]         flags_nxt;
  logic [7:0]         extind_r;
  logic [PC_W-1:0]    pc_r;
  logic [PC_W-1:0]    pc_nxt;
  logic               take;
  logic               fin;
  logic [7:0]         ob;
  logic               cb;
  logic [8:0]         sum9;
  logic [8:0]         dif9;
  logic [7:0]         neg8;
  logic [15:0]        wsum;
  logic [15:0]        wdif;
  logic [7:0]         lres;
  logic [7:0]         res8;
  logic [15:0]        prod;
  logic               prod_c;
  logic               m_as;
  logic               m_bs;
  logic               m_frac;
  logic               is_jump;
  logic               is_call;

  // Cycles taken by each operation
  function automatic logic [2:0] cycles_of(aluj_pkg::aluj_op_e op);
    case (op)
      aluj_pkg::OP_ADD_IMM_WORD, aluj_pkg::OP_SUB_IMM_WORD,
      aluj_pkg::OP_MULT_UNSIGNED, aluj_pkg::OP_MULT_SIGNED,
      aluj_pkg::OP_MULT_SIGNED_UNSIGNED, aluj_pkg::OP_FRAC_MULT_UNSIGNED,
      aluj_pkg::OP_FRAC_MULT_SIGNED, aluj_pkg::OP_FRAC_MULT_SIGNED_UNSIGNED,
      aluj_pkg::OP_RELATIVE_JUMP, aluj_pkg::OP_POINTER_JUMP,
      aluj_pkg::OP_EXTENDED_POINTER_JUMP:
        return aluj_pkg::CYC_TWO;
      aluj_pkg::OP_ABSOLUTE_JUMP:
        return aluj_pkg::CYC_DIRECT;
      aluj_pkg::OP_RELATIVE_CALL, aluj_pkg::OP_POINTER_CALL,
      aluj_pkg::OP_EXTENDED_POINTER_CALL:
        return aluj_pkg::CYC_CALL;
      default:
        return aluj_pkg::CYC_ONE;
    endcase
  endfunction : cycles_of

  // A new operation is taken while the previous one is on its last cycle
  assign take = OP_START && (rem_r <= aluj_pkg::CYC_ONE);
  assign fin  = (rem_r == aluj_pkg::CYC_ONE);

  // Cycle countdown for the running operation
  always_comb
  begin
    if (take)
    begin
      rem_nxt = cycles_of(OP_CODE);
    end
    else if (rem_r != 3'h0)
    begin
      rem_nxt = rem_r - 3'h1;
    end
    else
    begin
      rem_nxt = 3'h0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      rem_r <= 3'h0;
      BUSY  <= 1'b0;
    end
    else
    begin
      rem_r <= rem_nxt;
      BUSY  <= (rem_nxt > aluj_pkg::CYC_ONE);
    end
  end

  // Operand capture on take
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      op_r   <= aluj_pkg::OP_NOP;
      d_r    <= 8'h00;
      dh_r   <= 8'h00;
      r_r    <= 8'h00;
      k_r    <= 8'h00;
      z_r    <= 16'h0000;
      ofs_r  <= '0;
      addr_r <= '0;
    end
    else if (take)
    begin
      op_r   <= OP_CODE;
      d_r    <= OP_D;
      dh_r   <= OP_DH;
      r_r    <= OP_R;
      k_r    <= OP_K;
      z_r    <= OP_Z;
      ofs_r  <= OP_OFS;
      addr_r <= OP_ADDR;
    end
  end

  // Second operand and carry in selection
  always_comb
  begin
    ob = r_r;
    cb = 1'b0;
    case (op_r)
      aluj_pkg::OP_ADC, aluj_pkg::OP_SUB_REGS_CARRY:
        cb = flags_r[C];
      aluj_pkg::OP_SUB_IMM:
        ob = k_r;
      aluj_pkg::OP_SUB_IMM_CARRY:
      begin
        ob = k_r;
        cb = flags_r[C];
      end
      default:
        ob = r_r;
    endcase
  end

  // Adders shared by the byte and word operations
  assign sum9 = {1'b0, d_r} + {1'b0, ob} + {8'h00, cb};
  assign dif9 = {1'b0, d_r} - {1'b0, ob} - {8'h00, cb};
  assign neg8 = aluj_pkg::ALL_ZERO - d_r;
  assign wsum = {dh_r, d_r} + {8'h00, k_r};
  assign wdif = {dh_r, d_r} - {8'h00, k_r};

  // Logic unit for masks, test and clear
  always_comb
  begin
    case (op_r)
      aluj_pkg::OP_AND:             lres = d_r & r_r;
      aluj_pkg::OP_AND_IMM:         lres = d_r & k_r;
      aluj_pkg::OP_OR:              lres = d_r | r_r;
      aluj_pkg::OP_OR_IMM:          lres = d_r | k_r;
      aluj_pkg::OP_XOR_REGS:        lres = d_r ^ r_r;
      aluj_pkg::OP_SET_BITS_MASK:   lres = d_r | k_r;
      aluj_pkg::OP_CLEAR_BITS_MASK:
        lres = d_r & (aluj_pkg::ALL_ONES - k_r);
      aluj_pkg::OP_TEST_REG:        lres = d_r & d_r;
      aluj_pkg::OP_ZERO_REG:        lres = d_r ^ d_r;
      default:                      lres = 8'h00;
    endcase
  end

  // Multiplier mode decode
  assign m_as   = (op_r == aluj_pkg::OP_MULT_SIGNED) ||
                  (op_r == aluj_pkg::OP_MULT_SIGNED_UNSIGNED) ||
                  (op_r == aluj_pkg::OP_FRAC_MULT_SIGNED) ||
                  (op_r == aluj_pkg::OP_FRAC_MULT_SIGNED_UNSIGNED);
  assign m_bs   = (op_r == aluj_pkg::OP_MULT_SIGNED) ||
                  (op_r == aluj_pkg::OP_FRAC_MULT_SIGNED);
  assign m_frac = (op_r == aluj_pkg::OP_FRAC_MULT_UNSIGNED) ||
                  (op_r == aluj_pkg::OP_FRAC_MULT_SIGNED) ||
                  (op_r == aluj_pkg::OP_FRAC_MULT_SIGNED_UNSIGNED);

  aluj_mult #(
    .W        (8)
  ) u_mult (
    .a        (d_r),
    .b        (r_r),
    .a_signed (m_as),
    .b_signed (m_bs),
    .frac     (m_frac),
    .prod     (prod),
    .carry    (prod_c)
  );

  // Byte result and flag update of the finishing operation
  always_comb
  begin
    res8      = lres;
    flags_nxt = flags_r;
    case (op_r)
      aluj_pkg::OP_ADD, aluj_pkg::OP_ADC:
      begin
        res8 = sum9[7:0];
        flags_nxt[C] = sum9[8];
        flags_nxt[Z] = (sum9[7:0] == 8'h00);
        flags_nxt[N] = sum9[7];
        flags_nxt[V] = (d_r[7] & ob[7] & ~sum9[7]) |
                       (~d_r[7] & ~ob[7] & sum9[7]);
        flags_nxt[H] = (d_r[3] & ob[3]) | (ob[3] & ~sum9[3]) |
                       (~sum9[3] & d_r[3]);
      end
      aluj_pkg::OP_SUB, aluj_pkg::OP_SUB_REGS_CARRY,
      aluj_pkg::OP_SUB_IMM, aluj_pkg::OP_SUB_IMM_CARRY:
      begin
        res8 = dif9[7:0];
        flags_nxt[C] = dif9[8];
        // Carry forms keep zero only while every byte was zero
        flags_nxt[Z] = (dif9[7:0] == 8'h00) & (cb | ~flags_r[Z] ?
                       (~cb | flags_r[Z]) : 1'b1) &
                       ((op_r == aluj_pkg::OP_SUB) ||
                        (op_r == aluj_pkg::OP_SUB_IMM) || flags_r[Z]);
        flags_nxt[N] = dif9[7];
        flags_nxt[V] = (d_r[7] & ~ob[7] & ~dif9[7]) |
                       (~d_r[7] & ob[7] & dif9[7]);
        flags_nxt[H] = (~d_r[3] & ob[3]) | (ob[3] & dif9[3]) |
                       (dif9[3] & ~d_r[3]);
      end
      aluj_pkg::OP_ADD_IMM_WORD:
      begin
        flags_nxt[C] = ~wsum[15] & dh_r[7];
        flags_nxt[Z] = (wsum == 16'h0000);
        flags_nxt[N] = wsum[15];
        flags_nxt[V] = ~dh_r[7] & wsum[15];
        flags_nxt[S] = wsum[15] ^ (~dh_r[7] & wsum[15]);
      end
      aluj_pkg::OP_SUB_IMM_WORD:
      begin
        flags_nxt[C] = wdif[15] & ~dh_r[7];
        flags_nxt[Z] = (wdif == 16'h0000);
        flags_nxt[N] = wdif[15];
        flags_nxt[V] = dh_r[7] & ~wdif[15];
        flags_nxt[S] = wdif[15] ^ (dh_r[7] & ~wdif[15]);
      end
      aluj_pkg::OP_AND, aluj_pkg::OP_AND_IMM, aluj_pkg::OP_OR,
      aluj_pkg::OP_OR_IMM, aluj_pkg::OP_XOR_REGS,
      aluj_pkg::OP_SET_BITS_MASK, aluj_pkg::OP_CLEAR_BITS_MASK,
      aluj_pkg::OP_TEST_REG, aluj_pkg::OP_ZERO_REG:
      begin
        flags_nxt[Z] = (lres == 8'h00);
        flags_nxt[N] = lres[7];
        flags_nxt[V] = 1'b0;
      end
      aluj_pkg::OP_ONES_COMPLEMENT:
      begin
        res8 = aluj_pkg::ALL_ONES - d_r;
        flags_nxt[C] = 1'b1;
        flags_nxt[Z] = (d_r == aluj_pkg::ALL_ONES);
        flags_nxt[N] = ~d_r[7];
        flags_nxt[V] = 1'b0;
      end
      aluj_pkg::OP_TWOS_COMPLEMENT:
      begin
        res8 = neg8;
        flags_nxt[C] = (neg8 != 8'h00);
        flags_nxt[Z] = (neg8 == 8'h00);
        flags_nxt[N] = neg8[7];
        flags_nxt[V] = (neg8 == aluj_pkg::MIN_NEG);
        flags_nxt[H] = neg8[3] | d_r[3];
      end
      aluj_pkg::OP_INCREMENT_REG:
      begin
        res8 = d_r + 8'h01;
        flags_nxt[Z] = (res8 == 8'h00);
        flags_nxt[N] = res8[7];
        flags_nxt[V] = (res8 == aluj_pkg::MIN_NEG);
      end
      aluj_pkg::OP_DECREMENT_REG:
      begin
        res8 = d_r - 8'h01;
        flags_nxt[Z] = (res8 == 8'h00);
        flags_nxt[N] = res8[7];
        flags_nxt[V] = (res8 == aluj_pkg::MAX_POS);
      end
      aluj_pkg::OP_FILL_REG_ONES:
        res8 = aluj_pkg::ALL_ONES;
      aluj_pkg::OP_MULT_UNSIGNED, aluj_pkg::OP_MULT_SIGNED,
      aluj_pkg::OP_MULT_SIGNED_UNSIGNED, aluj_pkg::OP_FRAC_MULT_UNSIGNED,
      aluj_pkg::OP_FRAC_MULT_SIGNED, aluj_pkg::OP_FRAC_MULT_SIGNED_UNSIGNED:
      begin
        flags_nxt[C] = prod_c;
        flags_nxt[Z] = (prod == 16'h0000);
      end
      default:
        res8 = lres;
    endcase
  end

  // Flow decode and next program counter
  assign is_call = (op_r == aluj_pkg::OP_RELATIVE_CALL) ||
                   (op_r == aluj_pkg::OP_POINTER_CALL) ||
                   (op_r == aluj_pkg::OP_EXTENDED_POINTER_CALL);
  assign is_jump = is_call || (op_r == aluj_pkg::OP_RELATIVE_JUMP) ||
                   (op_r == aluj_pkg::OP_POINTER_JUMP) ||
                   (op_r == aluj_pkg::OP_EXTENDED_POINTER_JUMP) ||
                   (op_r == aluj_pkg::OP_ABSOLUTE_JUMP);

  always_comb
  begin
    case (op_r)
      aluj_pkg::OP_RELATIVE_JUMP, aluj_pkg::OP_RELATIVE_CALL:
        pc_nxt = pc_r + PC_W'($signed(ofs_r)) + PC_W'(1);
      aluj_pkg::OP_POINTER_JUMP, aluj_pkg::OP_POINTER_CALL:
        pc_nxt = PC_W'(z_r);
      aluj_pkg::OP_EXTENDED_POINTER_JUMP,
      aluj_pkg::OP_EXTENDED_POINTER_CALL:
        pc_nxt = PC_W'({extind_r, z_r});
      aluj_pkg::OP_ABSOLUTE_JUMP:
        pc_nxt = addr_r;
      default:
        pc_nxt = pc_r + PC_W'(1);
    endcase
  end

  // Results, write strobes and program counter at the last cycle
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      RES_LO    <= 8'h00;
      RES_HI    <= 8'h00;
      WR_DEST   <= 1'b0;
      WR_PAIR   <= 1'b0;
      WR_PROD   <= 1'b0;
      DONE      <= 1'b0;
      PC_LOAD   <= 1'b0;
      CALL_PUSH <= 1'b0;
      RET_PC    <= '0;
      pc_r      <= '0;
    end
    else
    begin
      WR_DEST   <= 1'b0;
      WR_PAIR   <= 1'b0;
      WR_PROD   <= 1'b0;
      PC_LOAD   <= 1'b0;
      CALL_PUSH <= 1'b0;
      DONE      <= fin && (op_r != aluj_pkg::OP_NOP);
      if (fin && (op_r != aluj_pkg::OP_NOP))
      begin
        pc_r    <= pc_nxt;
        PC_LOAD <= is_jump;
        if (is_call)
        begin
          CALL_PUSH <= 1'b1;
          RET_PC    <= pc_r + PC_W'(1);
        end
        if (op_r == aluj_pkg::OP_ADD_IMM_WORD)
        begin
          {RES_HI, RES_LO} <= wsum;
          WR_PAIR <= 1'b1;
        end
        else if (op_r == aluj_pkg::OP_SUB_IMM_WORD)
        begin
          {RES_HI, RES_LO} <= wdif;
          WR_PAIR <= 1'b1;
        end
        else if (m_as || m_frac || (op_r == aluj_pkg::OP_MULT_UNSIGNED))
        begin
          {RES_HI, RES_LO} <= prod;
          WR_PROD <= 1'b1;
        end
        else if (!is_jump)
        begin
          RES_LO  <= res8;
          WR_DEST <= 1'b1;
        end
      end
    end
  end

  // Flag and extended register store; hardware update beats software
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      flags_r  <= aluj_pkg::FLAGS_RST;
      extind_r <= aluj_pkg::EXTIND_RST;
    end
    else
    begin
      if (fin && !is_jump)
      begin
        flags_r <= flags_nxt;
      end
      else if (REG_WR && (REG_ADDR == aluj_pkg::REG_FLAGS))
      begin
        flags_r <= REG_WDATA;
      end
      if (REG_WR && (REG_ADDR == aluj_pkg::REG_EXTIND))
      begin
        extind_r <= REG_WDATA;
      end
    end
  end

  // Register read data, valid the cycle after the strobe only
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      REG_RDATA <= 8'h00;
    end
    else if (REG_RD)
    begin
      case (REG_ADDR)
        aluj_pkg::REG_FLAGS:  REG_RDATA <= flags_r;
        aluj_pkg::REG_EXTIND: REG_RDATA <= extind_r;
        aluj_pkg::REG_STATE:  REG_RDATA <= {5'h00, rem_r};
        default:              REG_RDATA <= 8'h00;
      endcase
    end
    else
    begin
      REG_RDATA <= 8'h00;
    end
  end

  assign FLAGS  = flags_r;
  assign PC_OUT = pc_r;

  AST_ADD_SUM: assert property (@(posedge CLK) disable iff (!RST_B)
    fin && (op_r == aluj_pkg::OP_ADD) |=>
      WR_DEST && (RES_LO == 8'($past(d_r) + $past(r_r))))
    else $error("add result wrong");
  AST_CARRY_KEPT: assert property (@(posedge CLK) disable iff (!RST_B)
    fin && (op_r == aluj_pkg::OP_INCREMENT_REG) |=> FLAGS[C] == $past(FLAGS[C]))
    else $error("increment changed carry");
  AST_FILL_FLAGS: assert property (@(posedge CLK) disable iff (!RST_B)
    fin && (op_r == aluj_pkg::OP_FILL_REG_ONES) && !REG_WR |=>
      $stable(FLAGS) && (RES_LO == aluj_pkg::ALL_ONES))
    else $error("fill ones touched flags");
  AST_LOGIC_V: assert property (@(posedge CLK) disable iff (!RST_B)
    fin && (op_r == aluj_pkg::OP_XOR_REGS) |=> !FLAGS[V] && WR_DEST)
    else $error("logic op left overflow set");
  AST_MULT_TWO: assert property (@(posedge CLK) disable iff (!RST_B)
    take && (OP_CODE == aluj_pkg::OP_MULT_UNSIGNED) |->
      ##2 !WR_PROD ##1 WR_PROD)
    else $error("multiply not two cycles");
  AST_FRAC_SHIFT: assert property (@(posedge CLK) disable iff (!RST_B)
    fin && (op_r == aluj_pkg::OP_FRAC_MULT_UNSIGNED) |=> WR_PROD &&
      ({RES_HI, RES_LO} ==
       16'(({8'h00, $past(d_r)} * {8'h00, $past(r_r)}) << 1)))
    else $error("fractional product not shifted");
  AST_PTR_JUMP: assert property (@(posedge CLK) disable iff (!RST_B)
    take && (OP_CODE == aluj_pkg::OP_POINTER_JUMP) |->
      ##3 PC_LOAD && (PC_OUT == PC_W'($past(OP_Z, 3))))
    else $error("pointer jump target wrong");
  AST_CALL_FOUR: assert property (@(posedge CLK) disable iff (!RST_B)
    take && (OP_CODE == aluj_pkg::OP_POINTER_CALL) |=>
      BUSY [*3] ##1 !BUSY ##1 (PC_LOAD && CALL_PUSH))
    else $error("pointer call not four cycles");
  AST_DIRECT_THREE: assert property (@(posedge CLK) disable iff (!RST_B)
    take && (OP_CODE == aluj_pkg::OP_ABSOLUTE_JUMP) |->
      ##4 PC_LOAD && (PC_OUT == $past(OP_ADDR, 4)))
    else $error("absolute jump wrong");

endmodule : aluj_datapath

// >>> aluj_regfile_model.sv
// Register file model fed by the datapath write strobes
`timescale 1ns/100ps
module aluj_regfile_model (
  input  wire logic        clk,
  input  wire logic        wr_dest,
  input  wire logic        wr_pair,
  input  wire logic        wr_prod,
  input  wire logic [15:0] res,
  output logic      [15:0] dest_q,
  output logic      [15:0] pair_q,
  output logic      [15:0] prod_q
);
  // Each strobe lands in its own storage
  always_ff @(posedge clk)
  begin
    if (wr_dest) dest_q <= {8'h00, res[7:0]};
    if (wr_pair) pair_q <= res;
    if (wr_prod) prod_q <= res;
  end
endmodule : aluj_regfile_model

// >>> test_aluj_datapath.sv
// Self-checking bench for the arithmetic and program flow datapath
`timescale 1ns/100ps
module test_aluj_datapath;
  logic        CLK, RST_B, OP_START, REG_WR, REG_RD, BUSY, DONE, WR_DEST;
  logic        WR_PAIR, WR_PROD, PC_LOAD, CALL_PUSH;
  logic [7:0]  OP_D, OP_DH, OP_R, OP_K, REG_WDATA, REG_RDATA, RES_LO, RES_HI;
  logic [7:0]  FLAGS;
  logic [15:0] OP_Z, dest_q, pair_q, prod_q;
  logic [11:0] OP_OFS;
  logic [21:0] OP_ADDR, PC_OUT, RET_PC, pc;
  logic [1:0]  REG_ADDR;
  int          n_errors, n_compared, cyc;
  aluj_pkg::aluj_op_e OP_CODE;

  aluj_datapath aluj_datapath_i (.CLK, .RST_B, .OP_START, .OP_CODE, .OP_D,
    .OP_DH, .OP_R, .OP_K, .OP_Z, .OP_OFS, .OP_ADDR, .REG_ADDR, .REG_WDATA,
    .REG_WR, .REG_RD, .REG_RDATA, .BUSY, .DONE, .RES_LO, .RES_HI, .WR_DEST,
    .WR_PAIR, .WR_PROD, .FLAGS, .PC_OUT, .PC_LOAD, .CALL_PUSH, .RET_PC);
  aluj_regfile_model aluj_regfile_model_i (.clk(CLK), .wr_dest(WR_DEST),
    .wr_pair(WR_PAIR), .wr_prod(WR_PROD), .res({RES_HI, RES_LO}), .dest_q,
    .pair_q, .prod_q);

  // Free running clock
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end

  // Hang guard
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      final_report();
    end
  end

  task automatic cmp(string what, logic [23:0] exp, logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic final_report();
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // One-cycle register write and read strobes
  task automatic wr(logic [1:0] a, logic [7:0] v);
    @(posedge CLK);
    REG_ADDR  <= a;
    REG_WDATA <= v;
    REG_WR    <= 1'b1;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask : wr

  task automatic rd(logic [1:0] a, logic [7:0] ex);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_RD   <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    cmp("rdata", 24'(ex), 24'(REG_RDATA));
  endtask : rd

  // Issue one operation, time it, then check flags and its result
  task automatic run(aluj_pkg::aluj_op_e c, logic [15:0] a, logic [7:0] r,
                     int n, logic [23:0] ex, logic [7:0] fl, int kind);
    int k;
    @(posedge CLK);
    OP_CODE       <= c;
    {OP_DH, OP_D} <= a;
    OP_Z          <= a;
    OP_R          <= r;
    OP_K          <= r;
    OP_OFS        <= {{4{r[7]}}, r};
    OP_ADDR       <= ex[21:0];
    OP_START      <= 1'b1;
    @(posedge CLK);
    OP_START <= 1'b0;
    k = 0;
    do
    begin
      @(posedge CLK);
      #1;
      k++;
    end
    while (DONE !== 1'b1 && k < 8);
    cmp("cycles", 24'(n), 24'(k));
    cmp("flags", 24'(fl), 24'(FLAGS));
    if (kind > 2)
    begin
      cmp("pc", ex, 24'(PC_OUT));
      cmp("strobes", {22'h0, 1'b1, kind == 4}, {22'h0, PC_LOAD, CALL_PUSH});
      if (kind == 4) cmp("ret", 24'(pc + 22'h1), 24'(RET_PC));
      pc = ex[21:0];
    end
    else
    begin
      @(posedge CLK);
      #1;
      cmp("result", ex,
          {8'h00, kind == 0 ? dest_q : (kind == 1 ? pair_q : prod_q)});
      pc++;
    end
  endtask : run

  // Reset, every operation class, register port, then program flow
  initial
  begin
    {RST_B, OP_START, REG_WR, REG_RD, REG_ADDR, REG_WDATA} = '0;
    {OP_D, OP_DH, OP_R, OP_K, OP_Z, OP_OFS, OP_ADDR} = '0;
    OP_CODE = aluj_pkg::OP_NOP;
    pc = 22'h0;
    repeat (10) @(posedge CLK);
    RST_B <= 1'b1;
    rd(aluj_pkg::REG_FLAGS, aluj_pkg::FLAGS_RST);
    run(aluj_pkg::OP_ADD, 16'h7F, 8'h01, 1, 24'h80, 8'h2C, 0);
    run(aluj_pkg::OP_SUB, 16'h00, 8'h01, 1, 24'hFF, 8'h25, 0);
    run(aluj_pkg::OP_SUB_REGS_CARRY, 16'h05, 8'h05, 1, 24'hFF, 8'h25, 0);
    run(aluj_pkg::OP_AND_IMM, 16'hF0, 8'h3C, 1, 24'h30, 8'h21, 0);
    run(aluj_pkg::OP_INCREMENT_REG, 16'h7F, 8'h00, 1, 24'h80, 8'h2D, 0);
    run(aluj_pkg::OP_DECREMENT_REG, 16'h01, 8'h00, 1, 24'h00, 8'h23, 0);
    run(aluj_pkg::OP_XOR_REGS, 16'h5A, 8'hA5, 1, 24'hFF, 8'h25, 0);
    run(aluj_pkg::OP_ADC, 16'h01, 8'h01, 1, 24'h03, 8'h00, 0);
    run(aluj_pkg::OP_SUB_IMM, 16'h10, 8'h10, 1, 24'h00, 8'h02, 0);
    run(aluj_pkg::OP_SUB_IMM_CARRY, 16'h00, 8'h00, 1, 24'h0, 8'h02, 0);
    run(aluj_pkg::OP_TWOS_COMPLEMENT, 16'h01, 8'h0, 1, 24'hFF, 8'h25, 0);
    run(aluj_pkg::OP_CLEAR_BITS_MASK, 16'hFF, 8'hF0, 1, 24'h0F, 8'h21, 0);
    run(aluj_pkg::OP_SET_BITS_MASK, 16'h00, 8'h80, 1, 24'h80, 8'h25, 0);
    run(aluj_pkg::OP_ZERO_REG, 16'h80, 8'h00, 1, 24'h00, 8'h23, 0);
    run(aluj_pkg::OP_FILL_REG_ONES, 16'h00, 8'h00, 1, 24'hFF, 8'h23, 0);
    run(aluj_pkg::OP_TEST_REG, 16'h80, 8'h00, 1, 24'h80, 8'h25, 0);
    run(aluj_pkg::OP_ONES_COMPLEMENT, 16'hFF, 8'h00, 1, 24'h00, 8'h23, 0);
    run(aluj_pkg::OP_OR, 16'h0F, 8'hF0, 1, 24'hFF, 8'h25, 0);
    run(aluj_pkg::OP_OR_IMM, 16'h00, 8'h00, 1, 24'h00, 8'h23, 0);
    run(aluj_pkg::OP_AND, 16'hC3, 8'h81, 1, 24'h81, 8'h25, 0);
    run(aluj_pkg::OP_ADD_IMM_WORD, 16'hFF, 8'h01, 2, 24'h100, 8'h20, 1);
    run(aluj_pkg::OP_SUB_IMM_WORD, 16'h0, 8'h01, 2, 24'hFFFF, 8'h35, 1);
    run(aluj_pkg::OP_MULT_UNSIGNED, 16'hFF, 8'hFF, 2, 24'hFE01, 8'h35, 2);
    run(aluj_pkg::OP_MULT_SIGNED, 16'hFF, 8'hFF, 2, 24'h1, 8'h34, 2);
    run(aluj_pkg::OP_MULT_SIGNED_UNSIGNED, 16'hFF, 8'h02, 2, 24'hFFFE, 8'h35, 2);
    run(aluj_pkg::OP_FRAC_MULT_UNSIGNED, 16'h40, 8'h40, 2, 24'h2000, 8'h34, 2);
    run(aluj_pkg::OP_FRAC_MULT_SIGNED, 16'hC0, 8'h40, 2, 24'hE000, 8'h35, 2);
    run(aluj_pkg::OP_FRAC_MULT_SIGNED_UNSIGNED, 16'h0, 8'h55, 2, 24'h0, 8'h36, 2);
    rd(aluj_pkg::REG_FLAGS, 8'h36);
    wr(aluj_pkg::REG_FLAGS, 8'hC3);
    rd(aluj_pkg::REG_FLAGS, 8'hC3);
    wr(aluj_pkg::REG_EXTIND, 8'h3A);
    rd(aluj_pkg::REG_EXTIND, 8'h3A);
    rd(2'h3, 8'h00);
    run(aluj_pkg::OP_POINTER_JUMP, 16'h1234, 8'h0, 2, 24'h1234, 8'hC3, 3);
    run(aluj_pkg::OP_RELATIVE_JUMP, 16'h0, 8'hFE, 2, 24'h1233, 8'hC3, 3);
    run(aluj_pkg::OP_ABSOLUTE_JUMP, 16'h0, 8'h0, 3, 24'h3ABCDE, 8'hC3, 3);
    run(aluj_pkg::OP_EXTENDED_POINTER_JUMP, 16'h5678, 8'h0, 2, 24'h3A5678, 8'hC3, 3);
    run(aluj_pkg::OP_RELATIVE_CALL, 16'h0, 8'h10, 4, 24'h3A5689, 8'hC3, 4);
    run(aluj_pkg::OP_POINTER_CALL, 16'h0100, 8'h0, 4, 24'h100, 8'hC3, 4);
    run(aluj_pkg::OP_EXTENDED_POINTER_CALL, 16'hFFFF, 8'h0, 4, 24'h3AFFFF, 8'hC3, 4);
    // A call in flight refuses a second start and reports cycles left
    @(posedge CLK);
    OP_CODE  <= aluj_pkg::OP_POINTER_CALL;
    OP_START <= 1'b1;
    @(posedge CLK);
    OP_CODE  <= aluj_pkg::OP_FILL_REG_ONES;
    @(posedge CLK);
    OP_START <= 1'b0;
    REG_ADDR <= aluj_pkg::REG_STATE;
    REG_RD   <= 1'b1;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1;
    cmp("state", 24'h3, 24'(REG_RDATA));
    final_report();
  end
endmodule : test_aluj_datapath
